// >>> agu_pkg.sv
package agu_pkg;

  // ===========================================================================
  // Widths
  localparam int ADDR_W      = 32;
  localparam int SEL_W       = 16;
  localparam int PORT_W      = 16;
  localparam int REG_IDX_W   = 3;
  localparam int SCALE_W     = 2;

  // ===========================================================================
  // General register indices
  localparam logic [2:0] STACK_POINTER_IDX = 3'h4;
  localparam logic [2:0] FRAME_BASE_IDX    = 3'h5;

  // ===========================================================================
  // Scale encodings (shift amounts)
  localparam logic [1:0] SCALE_1 = 2'h0;
  localparam logic [1:0] SCALE_2 = 2'h1;
  localparam logic [1:0] SCALE_4 = 2'h2;
  localparam logic [1:0] SCALE_8 = 2'h3;

  // ===========================================================================
  // Far pointer layout
  localparam int FAR_PTR_W    = 48;
  localparam int FAR_OFS_LSB  = 0;
  localparam int FAR_SEL_LSB  = 32;

  // ===========================================================================
  // Reset values
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [15:0] SEL_RST  = 16'h0000;

  typedef enum logic [1:0] {
    DISP_NONE,
    DISP_8,
    DISP_16,
    DISP_32
  } disp_size_e;

  typedef enum logic [2:0] {
    REF_FETCH,
    REF_STACK,
    REF_DATA,
    REF_STRING_DST,
    REF_FAR_PTR,
    REF_EXPLICIT,
    REF_IO
  } ref_kind_e;

  typedef enum logic [2:0] {
    SEG_STRING_TARGET,
    SEG_CODE,
    SEG_STACK,
    SEG_DATA,
    SEG_EXTRA_F,
    SEG_EXTRA_G
  } seg_sel_e;

endpackage : agu_pkg

// >>> ea_adder.sv
`timescale 1ns/1ps

module ea_adder (
  input  wire logic [31:0] disp_ext,
  input  wire logic [31:0] base_val,
  input  wire logic [31:0] index_val,
  input  wire logic        base_en,
  input  wire logic        index_en,
  input  wire logic [1:0]  scale,
  input  wire logic        addr32,
  output logic      [31:0] ea
);

  logic [31:0] base_term;
  logic [31:0] index_term;
  logic [31:0] sum;

  always_comb begin
    base_term  = base_en ? base_val : agu_pkg::ADDR_RST;
    // Shift is modulo 2^32, so signed index wraps correctly
    index_term = index_en ? (index_val << scale) : agu_pkg::ADDR_RST;  // see [RULE3] see [RULE5]
    sum        = disp_ext + base_term + index_term;                    // see [RULE1] see [RULE4]
    // Carry out of the active width is dropped
    ea         = addr32 ? sum : {16'h0000, sum[15:0]};                 // see [RULE18] see [RULE19]
  end

endmodule : ea_adder

// >>> operand_addr_gen.sv
`timescale 1ns/1ps

// Summary of operation
// [RULE1] Offset is displacement plus base plus scaled index
// [RULE2] Displacement may be 8, 16 or 32 bits
// [RULE3] Index scaled by 2, 4 or 8
// [RULE4] Components added as signed two's complement
// [RULE5] Scale only applies when index present
// [RULE6] Stack pointer never usable as index
// [RULE7] Stack or frame base selects stack segment
// [RULE8] Fetches always use code segment
// [RULE9] Push and pop always use stack segment
// [RULE10] String destinations always use string target segment
// [RULE11] Other data defaults to data segment
// [RULE12] Override prefix replaces default data segment
// [RULE13] Explicit selector is 16 bits, memory or register
// [RULE14] Far pointer: offset dword, then selector word
// [RULE15] Offset paired with selector names an operand
// [RULE16] Separate 64K byte-port I/O space, wider ports allowed
// [RULE17] Port from immediate or port address register
// [RULE18] Address size picks 16 or 32 bit offsets
// [RULE19] Sum truncated to active address size
module operand_addr_gen #(
  parameter int ADDR_W = agu_pkg::ADDR_W,
  parameter int PORT_W = agu_pkg::PORT_W
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  input  wire logic                    req_valid,
  input  wire agu_pkg::ref_kind_e      ref_kind,
  input  wire logic                    addr32,
  input  wire logic [31:0]             disp_raw,
  input  wire agu_pkg::disp_size_e     disp_size,
  input  wire logic                    base_en,
  input  wire logic [2:0]              base_idx,
  input  wire logic [31:0]             base_val,
  input  wire logic                    index_en,
  input  wire logic [2:0]              index_idx,
  input  wire logic [31:0]             index_val,
  input  wire logic [1:0]              scale,
  input  wire logic                    override_en,
  input  wire agu_pkg::seg_sel_e       override_seg,
  input  wire logic [31:0]             fetch_offset,
  input  wire logic                    sel_from_mem,
  input  wire logic [15:0]             sel_mem_val,
  input  wire logic [15:0]             sel_reg_val,
  input  wire logic [47:0]             far_ptr,
  input  wire logic                    io_use_imm,
  input  wire logic [7:0]              io_imm,
  input  wire logic [15:0]             port_address_reg,
  input  wire logic [1:0]              io_width,
  output logic                         out_valid,
  output agu_pkg::seg_sel_e            seg_out,
  output logic [31:0]                  offset_out,
  output logic                         sel_valid,
  output logic [15:0]                  sel_out,
  output logic                         io_valid,
  output logic [15:0]                  io_port,
  output logic [1:0]                   io_size,
  output logic                         index_fault
);

  // ===========================================================================
  // Parameter checks
  // The datapath is built for the full offset and port widths only
  if (ADDR_W != agu_pkg::ADDR_W) begin : g_bad_addr_w
    $error("operand_addr_gen: ADDR_W must equal the package offset width");
  end
  if (PORT_W != agu_pkg::PORT_W) begin : g_bad_port_w
    $error("operand_addr_gen: PORT_W must equal the package port width");
  end

  // ===========================================================================
  // Displacement sign extension
  logic [31:0] disp_ext;

  always_comb begin
    unique case (disp_size)                                                    // see [RULE2]
      agu_pkg::DISP_NONE: disp_ext = agu_pkg::ADDR_RST;
      agu_pkg::DISP_8:    disp_ext = {{24{disp_raw[7]}}, disp_raw[7:0]};       // see [RULE4]
      agu_pkg::DISP_16:   disp_ext = {{16{disp_raw[15]}}, disp_raw[15:0]};
      agu_pkg::DISP_32:   disp_ext = disp_raw;
    endcase
  end

  // ===========================================================================
  // Index qualification
  logic index_is_sp;
  logic index_ok;

  // A stack pointer index code is treated as no index, and flagged
  assign index_is_sp = index_en && (index_idx == agu_pkg::STACK_POINTER_IDX);  // see [RULE6]
  assign index_ok    = index_en && !index_is_sp;                               // see [RULE6]

  logic [31:0] ea;

  ea_adder u_ea_adder (
    .disp_ext  (disp_ext),
    .base_val  (base_val),
    .index_val (index_val),
    .base_en   (base_en),
    .index_en  (index_ok),
    .scale     (scale),
    .addr32    (addr32),
    .ea        (ea)
  );

  // ===========================================================================
  // Segment choice
  logic               stack_based;
  agu_pkg::seg_sel_e  data_default;
  agu_pkg::seg_sel_e  nxt_seg;
  logic [31:0]        nxt_offset;
  logic               nxt_sel_valid;
  logic [15:0]        nxt_sel;

  assign stack_based  = base_en && ((base_idx == agu_pkg::STACK_POINTER_IDX) ||
                                    (base_idx == agu_pkg::FRAME_BASE_IDX));
  assign data_default = stack_based ? agu_pkg::SEG_STACK : agu_pkg::SEG_DATA;   // see [RULE7] see [RULE11]

  always_comb begin
    nxt_seg       = data_default;
    nxt_offset    = ea;                                                         // see [RULE15]
    nxt_sel_valid = 1'b0;
    nxt_sel       = agu_pkg::SEL_RST;
    unique case (ref_kind)
      agu_pkg::REF_FETCH: begin
        nxt_seg    = agu_pkg::SEG_CODE;                                         // see [RULE8]
        nxt_offset = addr32 ? fetch_offset : {16'h0000, fetch_offset[15:0]};    // see [RULE18]
      end
      agu_pkg::REF_STACK: begin
        nxt_seg = agu_pkg::SEG_STACK;                                           // see [RULE9]
      end
      agu_pkg::REF_STRING_DST: begin
        nxt_seg = agu_pkg::SEG_STRING_TARGET;                                   // see [RULE10]
      end
      agu_pkg::REF_DATA: begin
        nxt_seg = override_en ? override_seg : data_default;                    // see [RULE12]
      end
      agu_pkg::REF_FAR_PTR: begin
        // Pointer is stored low dword first, selector word above it
        nxt_seg       = override_en ? override_seg : data_default;
        nxt_offset    = far_ptr[agu_pkg::FAR_OFS_LSB +: agu_pkg::ADDR_W];       // see [RULE14]
        nxt_sel_valid = 1'b1;
        nxt_sel       = far_ptr[agu_pkg::FAR_SEL_LSB +: agu_pkg::SEL_W];        // see [RULE14]
      end
      agu_pkg::REF_EXPLICIT: begin
        nxt_seg       = override_en ? override_seg : data_default;
        nxt_sel_valid = 1'b1;
        nxt_sel       = sel_from_mem ? sel_mem_val : sel_reg_val;               // see [RULE13]
      end
      agu_pkg::REF_IO: begin
        nxt_offset = agu_pkg::ADDR_RST;
      end
      default: begin
        nxt_seg = data_default;
      end
    endcase
  end

  // ===========================================================================
  // Memory reference outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      out_valid   <= 1'b0;
      seg_out     <= agu_pkg::SEG_DATA;
      offset_out  <= agu_pkg::ADDR_RST;
      sel_valid   <= 1'b0;
      sel_out     <= agu_pkg::SEL_RST;
      index_fault <= 1'b0;
    end else if (clk_en) begin
      out_valid   <= req_valid && (ref_kind != agu_pkg::REF_IO);
      index_fault <= req_valid && index_is_sp && (ref_kind != agu_pkg::REF_IO);  // see [RULE6]
      if (req_valid && (ref_kind != agu_pkg::REF_IO)) begin
        seg_out    <= nxt_seg;
        offset_out <= nxt_offset;
        sel_valid  <= nxt_sel_valid;
        sel_out    <= nxt_sel;
      end
    end
  end

  // ===========================================================================
  // I/O port address, its own 16-bit space apart from memory
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      io_valid <= 1'b0;
      io_port  <= agu_pkg::SEL_RST;
      io_size  <= 2'h0;
    end else if (clk_en) begin
      io_valid <= req_valid && (ref_kind == agu_pkg::REF_IO);                  // see [RULE16]
      if (req_valid && (ref_kind == agu_pkg::REF_IO)) begin
        io_port <= io_use_imm ? {8'h00, io_imm} : port_address_reg;            // see [RULE17]
        io_size <= io_width;                                                   // see [RULE16]
      end
    end
  end

endmodule : operand_addr_gen

// >>> agu_chk.sv
`timescale 1ns/1ps
module agu_chk (
  input logic               sys_clk,
  input logic               rst_n,
  input logic               clk_en,
  input logic               req_valid,
  input agu_pkg::ref_kind_e ref_kind,
  input logic               base_en,
  input logic [2:0]         base_idx,
  input logic               override_en,
  input agu_pkg::seg_sel_e  override_seg,
  input logic [47:0]        far_ptr,
  input logic               io_use_imm,
  input logic [7:0]         io_imm,
  input logic               out_valid,
  input agu_pkg::seg_sel_e  seg_out,
  input logic               sel_valid,
  input logic [15:0]        sel_out,
  input logic               io_valid,
  input logic [15:0]        io_port
);
  // =============
  // Helpers
  logic        go;
  logic        sb;
  logic [15:0] fs;
  assign go = clk_en && req_valid;
  assign sb = base_en && (base_idx == agu_pkg::STACK_POINTER_IDX || base_idx == agu_pkg::FRAME_BASE_IDX);
  assign fs = far_ptr[47:32];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_fetch_code_seg: assert property (
    go && ref_kind == agu_pkg::REF_FETCH |=> out_valid && seg_out == agu_pkg::SEG_CODE) else $error("fetch seg");
  a_stack_seg_fixed: assert property (
    go && ref_kind == agu_pkg::REF_STACK |=> seg_out == agu_pkg::SEG_STACK) else $error("stack seg");
  a_string_dst_seg: assert property (
    go && ref_kind == agu_pkg::REF_STRING_DST |=> seg_out == agu_pkg::SEG_STRING_TARGET) else $error("string seg");
  a_stack_base_seg: assert property (
    go && ref_kind == agu_pkg::REF_DATA && !override_en && sb |=> seg_out == agu_pkg::SEG_STACK) else $error("sb seg");
  a_data_default_seg: assert property (
    go && ref_kind == agu_pkg::REF_DATA && !override_en && !sb |=> seg_out == agu_pkg::SEG_DATA) else $error("ds seg");
  a_override_data_seg: assert property (
    go && ref_kind == agu_pkg::REF_DATA && override_en |=> seg_out == $past(override_seg)) else $error("override");
  a_far_sel_word: assert property (
    go && ref_kind == agu_pkg::REF_FAR_PTR |=> sel_valid && sel_out == $past(fs)) else $error("far selector");
  a_io_imm_port: assert property (
    go && ref_kind == agu_pkg::REF_IO && io_use_imm |=> io_valid && io_port == {8'h00, $past(io_imm)}) else $error("io");
endmodule : agu_chk
bind operand_addr_gen agu_chk chk_u (.*);

// >>> access_sink.sv
`timescale 1ns/1ps
module access_sink (
  input  logic sys_clk,
  input  logic rst_n,
  input  logic clk_en,
  input  logic out_valid,
  input  logic io_valid,
  output int   taken
);
  // A valid stands until the next enabled edge, so count only there
  always_ff @(posedge sys_clk) begin
    if (!rst_n) taken <= 0;
    else if (clk_en && (out_valid || io_valid)) taken <= taken + 1;
  end
endmodule : access_sink

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, req_valid = 1'b0, addr32 = 1'b0, acc, io;
  logic base_en = 1'b0, index_en = 1'b0, override_en = 1'b0, sel_from_mem = 1'b0, io_use_imm = 1'b0;
  logic [31:0] disp_raw = '0, base_val = '0, index_val = '0, fetch_offset = '0, r, d, s, seed = 32'hCC894C47;
  logic [2:0] base_idx = '0, index_idx = '0;
  logic [1:0] scale = '0, io_width = '0, io_size;
  logic [15:0] sel_mem_val = '0, sel_reg_val = '0, port_address_reg = '0, sel_out, io_port;
  logic [47:0] far_ptr = '0;
  logic [7:0] io_imm = '0;
  agu_pkg::ref_kind_e ref_kind = agu_pkg::REF_FETCH;
  agu_pkg::disp_size_e disp_size = agu_pkg::DISP_NONE;
  agu_pkg::seg_sel_e override_seg = agu_pkg::SEG_DATA, seg_out;
  logic out_valid, sel_valid, io_valid, index_fault;
  logic [31:0] offset_out;
  int errors = 0, num_checks = 0, cyc = 0, want = 0, taken;
  operand_addr_gen dut_u (.*);
  access_sink sink_u (.*);
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      close_out();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (exp !== got) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out();
    $display("errors %0d num_checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // =============
  // Random traffic
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    chk("reset seg", agu_pkg::SEG_DATA, seg_out);
    for (int i = 0; i < 3000; i++) begin
      r = rnd();
      clk_en = r[31:29] != 3'h0;
      req_valid = i < 2990 && r[28:27] != 2'h0;
      ref_kind = agu_pkg::ref_kind_e'(r[2:0] % 3'h7);
      addr32 = r[3];
      disp_size = agu_pkg::disp_size_e'(r[5:4]);
      {base_en, base_idx, index_en, index_idx, scale} = r[15:6];
      {override_en, sel_from_mem, io_use_imm, io_width} = r[20:16];
      override_seg = agu_pkg::seg_sel_e'(r[23:21] % 3'h6);
      io_imm = r[31:24];
      {sel_mem_val, sel_reg_val} = rnd();
      port_address_reg = sel_mem_val ^ sel_reg_val;
      far_ptr = {sel_reg_val, rnd()};
      disp_raw = rnd();
      base_val = rnd();
      index_val = rnd();
      fetch_offset = rnd();
      acc = clk_en && req_valid;
      io = ref_kind == agu_pkg::REF_IO;
      case (disp_size)
        agu_pkg::DISP_8: d = {{24{disp_raw[7]}}, disp_raw[7:0]};
        agu_pkg::DISP_16: d = {{16{disp_raw[15]}}, disp_raw[15:0]};
        agu_pkg::DISP_32: d = disp_raw;
        default: d = '0;
      endcase
      s = d + (base_en ? base_val : 0) + (index_en && index_idx != 3'h4 ? index_val << scale : 0);
      @(posedge sys_clk);
      #1;
      if (!acc) begin
        if (clk_en) chk("idle valid", 0, out_valid | io_valid);
      end else begin
        want++;
        chk("io_valid", io, io_valid);
        chk("out_valid", !io, out_valid);
        if (io) chk("io_port", io_use_imm ? {8'h00, io_imm} : port_address_reg, io_port);
        if (io) chk("io_size", io_width, io_size);
        if (!io) chk("sel_valid", ref_kind inside {agu_pkg::REF_FAR_PTR, agu_pkg::REF_EXPLICIT}, sel_valid);
        if (ref_kind == agu_pkg::REF_DATA) begin
          chk("offset", addr32 ? s : s[15:0], offset_out);
          chk("index_fault", index_en && index_idx == 3'h4, index_fault);
        end
        if (ref_kind == agu_pkg::REF_FAR_PTR && addr32) chk("far ofs", far_ptr[31:0], offset_out);
        if (ref_kind == agu_pkg::REF_EXPLICIT) chk("sel", sel_from_mem ? sel_mem_val : sel_reg_val, sel_out);
        if (ref_kind == agu_pkg::REF_FETCH) chk("fetch", addr32 ? fetch_offset : fetch_offset[15:0], offset_out);
        if (ref_kind == agu_pkg::REF_FETCH) chk("fetch seg", agu_pkg::SEG_CODE, seg_out);
      end
    end
    clk_en = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("results taken", want, taken);
    close_out();
  end
endmodule : tb
